// File: include/rtocr_pkg.sv
// Package for the read-to-own collision resolver: transaction and
// response encodings, carriers and the resolver state type.
// Assumes one synchronous clock domain shared by all users.
package rtocr_pkg;

    localparam int ADDR_W  = 32;
    localparam int IDX_W   = 8;
    localparam int IDX_LSB = 5;

    // Incoming coherent transaction types
    typedef enum logic [3:0] {
        TX_READ_HOME     = 4'h0,
        TX_IREAD_HOME    = 4'h1,
        TX_READ_OWNER    = 4'h2,
        TX_RTO_HOME      = 4'h3,
        TX_RTO_OWNER     = 4'h4,
        TX_DKILL_HOME    = 4'h5,
        TX_DKILL_SHARER  = 4'h6,
        TX_CASTOUT       = 4'h7,
        TX_TLBIE         = 4'h8,
        TX_TLBSYNC       = 4'h9,
        TX_IKILL_HOME    = 4'ha,
        TX_IKILL_SHARER  = 4'hb,
        TX_FLUSH         = 4'hc,
        TX_IO_READ_HOME  = 4'hd,
        TX_IO_READ_OWNER = 4'he,
        TX_NONE          = 4'hf
    } rtocr_txn_t;

    // Responses sent back to the fabric
    typedef enum logic [2:0] {
        RSP_DONE       = 3'h0,
        RSP_ERROR      = 3'h1,
        RSP_RETRY      = 3'h2,
        RSP_NOT_OWNER  = 3'h3,
        RSP_DONE_INTV  = 3'h4,
        RSP_NONE       = 3'h7
    } rtocr_rsp_t;

    // Kind of the outstanding own request
    typedef enum logic [1:0] {
        OUT_NONE     = 2'h0,
        OUT_RTO_HOME = 2'h1,
        OUT_RTO_OWN  = 2'h2
    } rtocr_out_t;

    // Final response collected for the own request
    typedef enum logic [1:0] {
        FIN_PENDING = 2'h0,
        FIN_DONE    = 2'h1,
        FIN_RETRY   = 2'h2,
        FIN_IDLE    = 2'h3
    } rtocr_fin_t;

    typedef struct packed {
        rtocr_txn_t          txn;
        logic                coherent;
        logic [ADDR_W-1:0]   addr;
        logic [7:0]          srcId;
    } rtocr_req_t;

    typedef struct packed {
        rtocr_rsp_t          rsp;
        logic                withData;
        logic                dataOnly;
        logic [7:0]          destId;
    } rtocr_ans_t;

    typedef struct packed {
        rtocr_txn_t          txn;
        logic [ADDR_W-1:0]   addr;
        logic                bcastIkill;
        logic                dirUpdate;
        logic                returnData;
    } rtocr_act_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_SEND = 3'b100
    } rtocr_state_t;

endpackage

// File: rtl/rtocr_match.sv
// Collision detector: compares an incoming request with the own outstanding one.
// Assumes both addresses are stable in the cycle they are compared.
`timescale 1ns/1ns
`default_nettype none
module rtocr_match
    import rtocr_pkg::*;
(
    input  wire logic [ADDR_W-1:0] inAddr,
    input  wire logic [ADDR_W-1:0] ownAddr,
    input  wire logic              ownValid,
    output logic                   hit
);
    // Same granule, or same cache index as a resource conflict
    assign hit = ownValid && ((inAddr[ADDR_W-1:IDX_LSB] == ownAddr[ADDR_W-1:IDX_LSB])
               || (inAddr[IDX_LSB+:IDX_W] == ownAddr[IDX_LSB+:IDX_W]));
endmodule
`default_nettype wire

// File: rtl/rtocr_table.sv
// Pure resolution table for collisions with an own read-to-own request.
// Assumes the caller has already established that a collision exists.
`timescale 1ns/1ns
`default_nettype none
module rtocr_table
    import rtocr_pkg::*;
(
    input  wire rtocr_out_t outKind,
    input  wire rtocr_txn_t txn,
    input  wire rtocr_fin_t fin,
    output rtocr_rsp_t      rsp,
    output logic            fwd,
    output logic            withData,
    output logic            dataOnly,
    output logic            needWait,
    output logic            bcast,
    output logic            dirUpd
);
    always_comb begin
        rsp      = RSP_NONE;
        fwd      = 1'b0;
        withData = 1'b0;
        dataOnly = 1'b0;
        needWait = 1'b0;
        bcast    = 1'b0;
        dirUpd   = 1'b0;
        if (outKind == OUT_RTO_HOME) begin
            case (txn)
                TX_READ_HOME, TX_IREAD_HOME, TX_RTO_HOME, TX_DKILL_HOME,
                TX_CASTOUT, TX_IKILL_HOME, TX_IO_READ_HOME: begin
                    rsp = RSP_ERROR;
                end
                TX_READ_OWNER, TX_RTO_OWNER: begin
                    needWait = (fin == FIN_PENDING);
                    if (fin == FIN_DONE) begin
                        rsp      = RSP_DONE_INTV;
                        fwd      = 1'b1;
                        withData = 1'b1;
                        dataOnly = 1'b1;
                    end else if (fin == FIN_RETRY) begin
                        rsp = RSP_ERROR;
                    end else if (fin == FIN_IDLE) begin
                        rsp = (txn == TX_READ_OWNER) ? RSP_NOT_OWNER : RSP_DONE;
                    end
                end
                TX_DKILL_SHARER: begin
                    needWait = (fin == FIN_PENDING);
                    if (fin == FIN_DONE) begin
                        rsp = RSP_ERROR;
                    end else if (fin != FIN_PENDING) begin
                        rsp = RSP_DONE;
                    end
                end
                TX_TLBIE, TX_TLBSYNC, TX_IKILL_SHARER: begin
                    rsp = RSP_DONE;
                    fwd = 1'b1;
                end
                TX_FLUSH, TX_IO_READ_OWNER: begin
                    needWait = (fin == FIN_PENDING);
                    if (fin == FIN_DONE) begin
                        rsp      = RSP_DONE;
                        fwd      = 1'b1;
                        withData = 1'b1;
                    end else if (fin == FIN_RETRY || txn == TX_FLUSH) begin
                        rsp = (fin == FIN_PENDING) ? RSP_NONE : RSP_ERROR;
                    end else if (fin == FIN_IDLE) begin
                        rsp = RSP_NOT_OWNER;
                    end
                end
                default: begin
                    rsp = RSP_NONE;
                end
            endcase
        end else if (outKind == OUT_RTO_OWN) begin
            case (txn)
                TX_READ_HOME, TX_IREAD_HOME, TX_RTO_HOME, TX_DKILL_HOME,
                TX_FLUSH, TX_IO_READ_HOME: begin
                    rsp = RSP_RETRY;
                end
                TX_READ_OWNER, TX_RTO_OWNER, TX_DKILL_SHARER, TX_IKILL_SHARER,
                TX_IO_READ_OWNER: begin
                    rsp = RSP_ERROR;
                end
                TX_CASTOUT: begin
                    rsp    = RSP_DONE;
                    dirUpd = 1'b1;
                end
                TX_IKILL_HOME: begin
                    fwd   = 1'b1;
                    bcast = 1'b1;
                end
                TX_TLBIE, TX_TLBSYNC: begin
                    rsp = RSP_DONE;
                    fwd = 1'b1;
                end
                default: begin
                    rsp = RSP_NONE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: rtl/rtocr_resolver.sv
// Read-to-own collision resolver: holds the own outstanding request,
// catches colliding coherent requests, waits for the final response when
// needed and issues the fabric answer and the local processor action.
// Assumes request and final-response inputs come from logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module rtocr_resolver
    import rtocr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        ownStart,
    input  wire rtocr_out_t  ownKind,
    input  wire logic [ADDR_W-1:0] ownAddr,
    input  wire logic        ownFinal,
    input  wire logic        ownRetry,
    input  wire logic        inValid,
    input  wire rtocr_req_t  inReq,
    output logic             inReady,
    output logic             passThru,
    output logic             ansValid,
    output rtocr_ans_t       ans,
    output logic             actValid,
    output rtocr_act_t       act,
    output logic             ownContinue,
    output logic             collErr
);
    rtocr_state_t  state_ff;
    rtocr_state_t  nxt_state;
    rtocr_out_t    ownKind_ff;
    logic [ADDR_W-1:0] ownAddr_ff;
    rtocr_fin_t    fin_ff;
    rtocr_req_t    held_ff;
    logic          ansValid_ff;
    rtocr_ans_t    ans_ff;
    logic          actValid_ff;
    rtocr_act_t    act_ff;
    logic          cont_ff;
    logic          err_ff;
    logic          pass_ff;
    logic          ready_ff;

    logic          hit;
    logic          isColl;
    rtocr_req_t    cur;
    rtocr_rsp_t    tRsp;
    logic          tFwd;
    logic          tData;
    logic          tDataOnly;
    logic          tWait;
    logic          tBcast;
    logic          tDir;
    logic          take;
    logic          resolve;

    assign cur  = (state_ff == ST_IDLE) ? inReq : held_ff;
    assign take = inValid && (state_ff == ST_IDLE);

    rtocr_match u_match (
        .inAddr   (cur.addr),
        .ownAddr  (ownAddr_ff),
        .ownValid (ownKind_ff != OUT_NONE),
        .hit      (hit)
    );

    // TLB ops, and castout against an OUT_RTO_OWN request, skip address matching; non-coherent never collides
    assign isColl = cur.coherent && (ownKind_ff != OUT_NONE)
                  && (hit || cur.txn == TX_TLBIE || cur.txn == TX_TLBSYNC
                      || (cur.txn == TX_CASTOUT && ownKind_ff == OUT_RTO_OWN));

    rtocr_table u_table (
        .outKind  (ownKind_ff),
        .txn      (cur.txn),
        .fin      (fin_ff),
        .rsp      (tRsp),
        .fwd      (tFwd),
        .withData (tData),
        .dataOnly (tDataOnly),
        .needWait (tWait),
        .bcast    (tBcast),
        .dirUpd   (tDir)
    );

    assign resolve = ((take && isColl) || state_ff == ST_WAIT) && !tWait;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take && isColl) begin
                    nxt_state = tWait ? ST_WAIT : ST_SEND;
                end
            end
            ST_WAIT: begin
                if (!tWait) begin
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            ready_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            // Registered copy so the ready output comes straight from a flop
            ready_ff <= (nxt_state == ST_IDLE);
        end
    end

    // Holding the request keeps the table inputs stable while waiting
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            held_ff <= '0;
        end else if (take) begin
            held_ff <= inReq;
        end
    end

    // Own request tracking; the final response ends the pending phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ownKind_ff <= OUT_NONE;
            ownAddr_ff <= '0;
            fin_ff     <= FIN_IDLE;
        end else if (ownStart) begin
            ownKind_ff <= ownKind;
            ownAddr_ff <= ownAddr;
            fin_ff     <= FIN_PENDING;
        end else if (ownFinal && fin_ff == FIN_PENDING) begin
            fin_ff <= ownRetry ? FIN_RETRY : FIN_DONE;
        end else if (state_ff == ST_SEND) begin
            // A collision resolved after the final response retires the entry, except a TX_DKILL_SHARER after a retry
            if (fin_ff == FIN_DONE || (fin_ff == FIN_RETRY && held_ff.txn != TX_DKILL_SHARER)) begin
                ownKind_ff <= OUT_NONE;
                fin_ff     <= FIN_IDLE;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ansValid_ff <= 1'b0;
            ans_ff      <= '0;
            actValid_ff <= 1'b0;
            act_ff      <= '0;
            cont_ff     <= 1'b0;
            err_ff      <= 1'b0;
        end else begin
            ansValid_ff <= resolve && (tRsp != RSP_NONE);
            ans_ff      <= '{rsp: tRsp, withData: tData, dataOnly: tDataOnly,
                             destId: cur.srcId};
            actValid_ff <= resolve && (tFwd || tDir || tBcast);
            act_ff      <= '{txn: tFwd ? cur.txn : TX_NONE, addr: cur.addr,
                             bcastIkill: tBcast, dirUpdate: tDir, returnData: tData};
            cont_ff     <= resolve && cur.txn == TX_DKILL_SHARER
                           && fin_ff == FIN_RETRY && ownKind_ff == OUT_RTO_HOME;
            err_ff      <= resolve && (tRsp == RSP_ERROR);
        end
    end

    // Requests that do not collide go to normal processing
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pass_ff <= 1'b0;
        end else begin
            pass_ff <= take && !isColl;
        end
    end

    assign inReady     = ready_ff;
    assign passThru    = pass_ff;
    assign ansValid    = ansValid_ff;
    assign ans         = ans_ff;
    assign actValid    = actValid_ff;
    assign act         = act_ff;
    assign ownContinue = cont_ff;
    assign collErr     = err_ff;
endmodule
`default_nettype wire

// File: sim/rtocr_resolver_asserts.sv
// Checker for the read-to-own collision resolver, bound to its top module.
// Assumes one clock domain and at most one own request pending at a time.
`timescale 1ns/1ns
`default_nettype none
module rtocr_resolver_asserts
    import rtocr_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              arst_n,
    input wire logic              ownStart,
    input wire rtocr_out_t        ownKind,
    input wire logic [ADDR_W-1:0] ownAddr,
    input wire logic              ownFinal,
    input wire logic              inValid,
    input wire rtocr_req_t        inReq,
    input wire logic              inReady,
    input wire logic              passThru,
    input wire logic              ansValid,
    input wire rtocr_ans_t        ans,
    input wire logic              actValid,
    input wire rtocr_act_t        act,
    input wire logic              collErr
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    logic              ownPend_ff;
    rtocr_out_t        ownKind_ff;
    logic [ADDR_W-1:0] ownAddr_ff;
    logic              hit;
    logic              home;
    logic              own;

    // Pending only until the final answer, so retired entries never arm a check
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ownPend_ff <= 1'b0;
        end else if (ownStart) begin
            ownPend_ff <= 1'b1;
        end else if (ownFinal) begin
            ownPend_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ownStart) begin
            ownKind_ff <= ownKind;
            ownAddr_ff <= ownAddr;
        end
    end

    assign hit  = inValid && inReady && inReq.coherent && ownPend_ff && inReq.addr == ownAddr_ff;
    assign home = ownKind_ff == OUT_RTO_HOME;
    assign own  = ownKind_ff == OUT_RTO_OWN;

    sequence sWait;
        hit && home && inReq.txn inside {TX_READ_OWNER, TX_RTO_OWNER, TX_DKILL_SHARER,
                                         TX_FLUSH, TX_IO_READ_OWNER};
    endsequence
    sequence sLate;
        !ansValid ##[0:40] ansValid;
    endsequence

    a_err_flag: assert property (collErr |-> ansValid && ans.rsp == RSP_ERROR)
        else $error("error flag without error answer");
    a_err_raise: assert property (ansValid && ans.rsp == RSP_ERROR |-> collErr)
        else $error("error answer without error flag");
    a_home_error: assert property (hit && home && inReq.txn inside {TX_READ_HOME,
        TX_IREAD_HOME, TX_RTO_HOME, TX_DKILL_HOME, TX_CASTOUT, TX_IKILL_HOME, TX_IO_READ_HOME}
        |=> ansValid && ans.rsp == RSP_ERROR) else $error("home collision not answered error");
    a_own_retry: assert property (hit && own && inReq.txn inside {TX_READ_HOME, TX_IREAD_HOME,
        TX_RTO_HOME, TX_DKILL_HOME, TX_FLUSH, TX_IO_READ_HOME}
        |=> ansValid && ans.rsp == RSP_RETRY) else $error("owner collision not retried");
    a_own_error: assert property (hit && own && inReq.txn inside {TX_READ_OWNER, TX_RTO_OWNER,
        TX_DKILL_SHARER, TX_IKILL_SHARER, TX_IO_READ_OWNER}
        |=> ansValid && ans.rsp == RSP_ERROR) else $error("owner collision not answered error");
    a_castout_dir: assert property (hit && own && inReq.txn == TX_CASTOUT
        |=> ansValid && ans.rsp == RSP_DONE && actValid && act.dirUpdate)
        else $error("castout not done with directory update");
    a_ikill_bcast: assert property (hit && own && inReq.txn == TX_IKILL_HOME
        |=> actValid && act.bcastIkill && !ansValid) else $error("ikill home not broadcast");
    a_tlb_fwd: assert property (hit && inReq.txn inside {TX_TLBIE, TX_TLBSYNC}
        |=> actValid && act.txn == $past(inReq.txn) && ansValid && ans.rsp == RSP_DONE)
        else $error("tlb request not forwarded and done");
    a_ikill_sh: assert property (hit && home && inReq.txn == TX_IKILL_SHARER
        |=> actValid && ansValid && ans.rsp == RSP_DONE) else $error("ikill sharer not done");
    a_wait_final: assert property (sWait |=> sLate)
        else $error("answer not held back for final response");
    a_noncoh_pass: assert property (inValid && inReady && !inReq.coherent
        && !(inReq.txn inside {TX_TLBIE, TX_TLBSYNC}) |=> passThru && !ansValid)
        else $error("non-coherent request treated as collision");
    a_index_hit: assert property (inValid && inReady && inReq.coherent && ownPend_ff
        && inReq.addr[IDX_LSB+:IDX_W] == ownAddr_ff[IDX_LSB+:IDX_W]
        && inReq.txn inside {TX_READ_HOME, TX_IREAD_HOME, TX_RTO_HOME, TX_DKILL_HOME}
        |=> !passThru) else $error("index conflict not caught");
endmodule
bind rtocr_resolver rtocr_resolver_asserts u_rtocr_resolver_asserts (.*);
`default_nettype wire

// File: sim/rtocr_peer.sv
// Far side model: returns the final response of the own request.
// Assumes one go pulse per own request; retry flag is junk outside final.
`timescale 1ns/1ns
`default_nettype none
module rtocr_peer (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       go,
    input  wire logic       retry,
    input  wire logic [3:0] dly,
    output logic            ownFinal,
    output logic            ownRetry
);
    logic [3:0] cnt_ff;
    logic       busy_ff;
    logic       retry_ff;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff  <= 1'b0;
            cnt_ff   <= 4'h0;
            retry_ff <= 1'b0;
            ownFinal <= 1'b0;
            ownRetry <= 1'b0;
        end else begin
            ownFinal <= 1'b0;
            // Toggles outside the final pulse so a stale flag is never trusted
            ownRetry <= ~ownRetry;
            if (go) begin
                busy_ff  <= 1'b1;
                cnt_ff   <= dly;
                retry_ff <= retry;
            end else if (busy_ff && cnt_ff == 4'h0) begin
                busy_ff  <= 1'b0;
                ownFinal <= 1'b1;
                ownRetry <= retry_ff;
            end else begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tb.sv
// Testbench: every incoming type against both own kinds, both final outcomes.
// Assumes the resolver is idle again 14 cycles after each request.
`timescale 1ns/1ns
`default_nettype none
module tb
    import rtocr_pkg::*;
;
    logic sys_clk, arst_n, ownStart, ownFinal, ownRetry, inValid, go, retry;
    logic inReady, passThru, ansValid, actValid, ownContinue, collErr;
    logic [ADDR_W-1:0] ownAddr;
    logic [3:0]        dly;
    logic [31:0]       seed;
    rtocr_out_t        ownKind;
    rtocr_req_t        inReq;
    rtocr_ans_t        ans, got;
    rtocr_act_t        act;
    rtocr_ans_t        expQ[$];
    logic [5:0]        side;
    logic [5:0]        sideQ[$];
    int                miscompares, checked;

    rtocr_resolver u_rtocr_resolver (.*);
    rtocr_peer     u_rtocr_peer (.*);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic rtocr_ans_t expAns(rtocr_out_t k, rtocr_txn_t t, logic r, logic [7:0] id);
        rtocr_ans_t a;
        a = '0;
        a.destId = id;
        if (k == OUT_RTO_HOME) begin
            case (t)
                TX_READ_OWNER, TX_RTO_OWNER: begin
                    a.rsp = r ? RSP_ERROR : RSP_DONE_INTV;
                    a.withData = !r;
                    a.dataOnly = !r;
                end
                TX_FLUSH, TX_IO_READ_OWNER: begin
                    a.rsp = r ? RSP_ERROR : RSP_DONE;
                    a.withData = !r;
                end
                TX_DKILL_SHARER: a.rsp = r ? RSP_DONE : RSP_ERROR;
                TX_TLBIE, TX_TLBSYNC, TX_IKILL_SHARER: a.rsp = RSP_DONE;
                default: a.rsp = RSP_ERROR;
            endcase
        end else begin
            case (t)
                TX_READ_OWNER, TX_RTO_OWNER, TX_DKILL_SHARER, TX_IKILL_SHARER,
                TX_IO_READ_OWNER: a.rsp = RSP_ERROR;
                TX_CASTOUT, TX_TLBIE, TX_TLBSYNC: a.rsp = RSP_DONE;
                TX_IKILL_HOME: a.rsp = RSP_NONE;
                default: a.rsp = RSP_RETRY;
            endcase
        end
        return a;
    endfunction

    // Expected {continue, action valid, forwarded type} alongside each answer
    function automatic logic [5:0] expSide(rtocr_out_t k, rtocr_txn_t t, logic r);
        logic fwd;
        fwd = (t inside {TX_TLBIE, TX_TLBSYNC})
            || (k == OUT_RTO_HOME && (t == TX_IKILL_SHARER
                || (!r && t inside {TX_READ_OWNER, TX_RTO_OWNER, TX_FLUSH, TX_IO_READ_OWNER})));
        return {k == OUT_RTO_HOME && t == TX_DKILL_SHARER && r,
                fwd || (k == OUT_RTO_OWN && t == TX_CASTOUT), fwd ? t : TX_NONE};
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Mode 0 exact match, 1 index conflict, 2 no conflict, 3 non-coherent
    task automatic run(rtocr_out_t k, rtocr_txn_t t, logic r);
        logic [ADDR_W-1:0] a;
        logic [1:0]        m;
        rtocr_ans_t        e;
        a = rnd();
        m = 2'(rnd());
        e = expAns(k, t, r, a[7:0]);
        if (t inside {TX_TLBIE, TX_TLBSYNC, TX_CASTOUT}) m = 2'd0;
        @(posedge sys_clk);
        ownStart <= 1'b1;
        ownKind  <= k;
        ownAddr  <= a;
        @(posedge sys_clk);
        ownStart <= 1'b0;
        ownAddr  <= ~a;
        inValid  <= 1'b1;
        inReq    <= '{t, m != 2'd3, m == 2'd2 ? a ^ 32'h40 : m == 2'd1 ? a ^ 32'h100000 : a, a[7:0]};
        if (m < 2'd2 && e.rsp != RSP_NONE) begin
            expQ.push_back(e);
            sideQ.push_back(expSide(k, t, r));
        end
        @(posedge sys_clk);
        inValid    <= 1'b0;
        inReq.addr <= rnd();
        go         <= 1'b1;
        retry      <= r;
        dly        <= 4'(2 + rnd() % 8);
        @(posedge sys_clk);
        go <= 1'b0;
        chk("pass through", passThru, m[1]);
        repeat (14) @(posedge sys_clk);
        chk("missing answers", expQ.size(), 0);
        chk("idle again", inReady, 1'b1);
    endtask

    always @(posedge sys_clk) begin
        if (ansValid === 1'b1) begin
            if (expQ.size() == 0) chk("spurious answer", 1, 0);
            else begin
                got = expQ.pop_front();
                side = sideQ.pop_front();
                chk("answer", 32'(ans), 32'(got));
                chk("error flag", collErr, got.rsp == RSP_ERROR);
                chk("side outputs", {ownContinue, actValid, act.txn}, side);
            end
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        seed = 32'h1128;
        arst_n = 1'b0;
        {ownStart, inValid, go, retry} = '0;
        ownKind = OUT_NONE;
        ownAddr = '0;
        inReq = '0;
        dly = '0;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        chk("reset outputs", {inReady, passThru, ansValid, actValid, collErr}, 5'h10);
        for (int p = 0; p < 2; p++)
            for (int k = 1; k < 3; k++)
                for (int t = 0; t < 15; t++)
                    for (int r = 0; r < 2; r++) run(rtocr_out_t'(k), rtocr_txn_t'(t), r[0]);
        give_verdict;
    end

    // Sweep needs about 2170 cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        give_verdict;
    end
endmodule
`default_nettype wire
